/* ctt_map.svh */
`ifndef CTT_MAP_SVH
`define CTT_MAP_SVH

// Register word indices; byte address is four times the index
`define CTT_IDX_CNT_HI   12'hF00
`define CTT_IDX_CNT_LO   12'hF01
`define CTT_IDX_RLD_HI   12'hF02
`define CTT_IDX_RLD_LO   12'hF03
`define CTT_IDX_CAP_HI   12'hF04
`define CTT_IDX_CAP_LO   12'hF05
`define CTT_IDX_CTL0     12'hF06
`define CTT_IDX_CTL1     12'hF07
`define CTT_IDX_IRQ_STAT 12'hF08
`define CTT_IDX_IRQ_MASK 12'hF09
`define CTT_IDX_T1_CTL0  12'hF0E

// Reset values and the count loaded on reload
`define CTT_RST_CTL0     8'h00
`define CTT_RST_CTL1     8'h00
`define CTT_RST_CNT      16'h0000
`define CTT_RST_RLD      16'hFFFF
`define CTT_CNT_START    16'h0001

// Interrupt source selection codes
`define CTT_SRC_BOTH     2'h0
`define CTT_SRC_CAPTURE  2'h1
`define CTT_SRC_RELOAD   2'h2

// Operating codes, {operating_code_msb, operating_code_low}
`define CTT_MODE_COUNTER 4'h2
`define CTT_MODE_CAPTURE 4'h4
`define CTT_MODE_CAPCMP  4'h7
`define CTT_MODE_DUALPWM 4'h8

// Status and mask bit positions
`define CTT_IRQ_CAP_BIT  0
`define CTT_IRQ_RLD_BIT  1

`endif

/* ctt_pkg.sv */
package ctt_pkg;

    // First control register layout
    typedef struct packed {
        logic       operating_code_msb;
        logic [1:0] irq_source_select;
        logic       reserved;
        logic [2:0] deadband_delay;
        logic       capture_caused_irq;
    } ctt_ctl0_t;

    // Second control register layout
    typedef struct packed {
        logic       enable;
        logic       edge_falling;
        logic [2:0] prescale;
        logic [2:0] operating_code_low;
    } ctt_ctl1_t;

    // Timer events of one cycle
    typedef struct packed {
        logic reload;
        logic capture;
    } ctt_evt_t;

    // Capture/compare start sequencing
    typedef enum logic {
        CTT_WAIT,
        CTT_RUN
    } ctt_cc_state_t;

endpackage : ctt_pkg

/* ctt_timer.sv */
// Behaviour
// R1 - Capture/compare counting waits for first selected input edge after enable
// R2 - That starting edge raises no interrupt
// R3 - Software picks rising or falling input edge for capture
// R4 - Interrupts on capture and reload by default; field can restrict either
// R5 - Software loads starting count, normally 0001H, before capture/compare
// R6 - Reload registers act as compare value in capture/compare
// R7 - Software sets pin function first, then enables timer last
// R8 - Reading count while enabled never disturbs counting
// R9 - Enabled high-byte read latches low byte; next low read returns it
// R10 - Disabled low-byte read returns live counter value
// R11 - Timer output inverts on every reload
// R12 - Input shares pin with complementary output; absent in dual PWM mode
// R13 - Control 0 bit 7 is the operating code MSB above control 1 field
// R14 - Control 0 resets to zero: source 6:5, reserved 4, deadband, status 0
// R15 - Status bit shows whether last interrupt came from capture
// R16 - Control registers are 8-bit read/write; control 0 bit 0 ignores writes here
// R17 - Capture edge stores count in readable capture register, sets status
`timescale 1ns/1ps
`include "ctt_map.svh"

module ctt_timer (
    input  wire logic        pclk,       // System clock
    input  wire logic        presetn,    // Async reset, active low
    input  wire logic        psel,       // APB select
    input  wire logic        penable,    // APB access phase
    input  wire logic        pwrite,     // APB write
    input  wire logic [15:0] paddr,      // APB byte address
    input  wire logic [31:0] pwdata,     // APB write data
    output logic      [31:0] prdata,     // APB read data
    output logic             pready,     // APB ready
    output logic             pslverr,    // APB error, unmapped
    output logic             irq,        // Level interrupt
    input  wire logic        tin_pin,    // Timer input from pin
    output logic             tout,       // Timer output
    output logic             tout_n,     // Complementary output
    output logic             tout_n_oe   // Drives shared pin
);

    // Registers
    ctt_pkg::ctt_ctl0_t    ctl0_q;
    ctt_pkg::ctt_ctl1_t    ctl1_q;
    ctt_pkg::ctt_cc_state_t cc_state_q;
    logic [15:0] cnt_q;
    logic [15:0] rld_q;
    logic [15:0] cap_q;
    logic [7:0]  hold_q;
    logic [1:0]  stat_q;
    logic [1:0]  mask_q;
    logic [6:0]  div_q;
    logic [2:0]  tin_sync_q;
    logic        en_prev_q;
    logic        tout_q;
    logic [31:0] prdata_q;
    logic        pready_q;
    logic        pslverr_q;
    logic        irq_q;

    // Bus decode
    wire         setup    = psel & ~penable;
    wire         done     = psel & penable & pready_q;
    wire         wr       = done & pwrite;
    wire         rd       = done & ~pwrite;
    wire [11:0]  idx      = paddr[13:2];
    wire         aligned  = (paddr[15:14] == 2'h0) & (paddr[1:0] == 2'h0);
    wire         a_cnt_hi = aligned & (idx == `CTT_IDX_CNT_HI);
    wire         a_cnt_lo = aligned & (idx == `CTT_IDX_CNT_LO);
    wire         a_rld_hi = aligned & (idx == `CTT_IDX_RLD_HI);
    wire         a_rld_lo = aligned & (idx == `CTT_IDX_RLD_LO);
    wire         a_cap_hi = aligned & (idx == `CTT_IDX_CAP_HI);
    wire         a_cap_lo = aligned & (idx == `CTT_IDX_CAP_LO);
    wire         a_ctl0   = aligned & (idx == `CTT_IDX_CTL0);
    wire         a_ctl1   = aligned & (idx == `CTT_IDX_CTL1);
    wire         a_stat   = aligned & (idx == `CTT_IDX_IRQ_STAT);
    wire         a_mask   = aligned & (idx == `CTT_IDX_IRQ_MASK);
    wire         mapped   = a_cnt_hi | a_cnt_lo | a_rld_hi | a_rld_lo |
                            a_cap_hi | a_cap_lo | a_ctl0 | a_ctl1 |
                            a_stat | a_mask;
    wire [7:0]   wbyte    = pwdata[7:0];

    // Operating code and mode flags
    wire [3:0]   mode     = {ctl0_q.operating_code_msb,
                             ctl1_q.operating_code_low}; // R13
    wire         en       = ctl1_q.enable;
    wire         m_cnt    = (mode == `CTT_MODE_COUNTER);
    wire         m_cap    = (mode == `CTT_MODE_CAPTURE);
    wire         m_cc     = (mode == `CTT_MODE_CAPCMP);
    wire         m_dual   = (mode == `CTT_MODE_DUALPWM);

    // Input edge from the synchroniser's last two stages
    wire         rise     = tin_sync_q[1] & ~tin_sync_q[2];
    wire         fall     = ~tin_sync_q[1] & tin_sync_q[2];
    wire         sel_edge = ctl1_q.edge_falling ? fall : rise; // R3
    wire         in_edge  = en & sel_edge & ~m_dual; // R12

    // Prescaler tick, divide by two to the prescale power
    wire [7:0]   ps_wide  = (8'h01 << ctl1_q.prescale) - 8'h01;
    wire [6:0]   ps_mask  = ps_wide[6:0];
    wire         tick     = en & ((div_q & ps_mask) == ps_mask);

    // Count enable and events
    wire         cc_run   = (cc_state_q == ctt_pkg::CTT_RUN);
    wire         inc      = m_cc  ? (tick & cc_run) :  // R1
                            m_cnt ? in_edge : tick;
    wire         match    = (cnt_q == rld_q); // R6
    ctt_pkg::ctt_evt_t evt;
    // One driver for the whole event word: reload, then capture
    assign evt = {inc & match,
                  in_edge & (m_cap | (m_cc & cc_run))}; // R2

    // Interrupt source filtering
    wire         src_cap  = (ctl0_q.irq_source_select !=
                             `CTT_SRC_RELOAD); // R4
    wire         src_rld  = (ctl0_q.irq_source_select !=
                             `CTT_SRC_CAPTURE); // R4
    wire         irq_cap  = evt.capture & src_cap;
    wire         irq_rld  = evt.reload & src_rld;
    wire [1:0]   evt_bits = {irq_rld, irq_cap};

    // Count write by software wins over counting
    wire         cnt_wr   = wr & (a_cnt_hi | a_cnt_lo);
    wire [15:0]  cnt_inc  = cnt_q + 16'h0001;
    wire [15:0]  cnt_next = evt.reload ? `CTT_CNT_START : cnt_inc;

    // Enable rising edge restarts the start sequence
    wire         en_rise  = en & ~en_prev_q;

    // Read data selection
    wire [7:0]   cnt_lo_rd = en ? hold_q : cnt_q[7:0]; // R9 R10
    wire [7:0]   rsel =
        a_cnt_hi ? cnt_q[15:8] :
        a_cnt_lo ? cnt_lo_rd :
        a_rld_hi ? rld_q[15:8] :
        a_rld_lo ? rld_q[7:0] :
        a_cap_hi ? cap_q[15:8] :
        a_cap_lo ? cap_q[7:0] :
        a_ctl0   ? ctl0_q :
        a_ctl1   ? ctl1_q :
        a_stat   ? {6'h00, stat_q} :
        a_mask   ? {6'h00, mask_q} : 8'h00;

    // Status next value; a new event wins over a clear
    wire [1:0]   stat_clr = (wr & a_stat) ? wbyte[1:0] : 2'h0;
    wire [1:0]   stat_d   = (stat_q & ~stat_clr) | evt_bits;
    // Mask next value, so the interrupt follows a mask write at once
    wire [1:0]   mask_d   = (wr & a_mask) ? wbyte[1:0] : mask_q;

    // APB answer: ready in the first access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q  <= 1'b0;
            prdata_q  <= 32'h0000_0000;
            pslverr_q <= 1'b0;
        end else begin
            pready_q  <= setup;
            pslverr_q <= setup & ~mapped;
            if (setup) begin
                prdata_q <= {24'h00_0000, rsel};
            end
        end
    end

    // Control registers, 8-bit read/write except status bit 0 of control 0
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctl0_q <= `CTT_RST_CTL0; // R14
            ctl1_q <= `CTT_RST_CTL1;
        end else begin
            if (wr & a_ctl0) begin
                ctl0_q[7:1] <= wbyte[7:1]; // R16
            end
            if (irq_cap) begin
                ctl0_q.capture_caused_irq <= 1'b1; // R15 R17
            end else if (irq_rld) begin
                ctl0_q.capture_caused_irq <= 1'b0; // R15
            end
            if (wr & a_ctl1) begin
                ctl1_q <= wbyte; // R16
            end
        end
    end

    // Reload and capture holding registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rld_q <= `CTT_RST_RLD;
            cap_q <= `CTT_RST_CNT;
        end else begin
            if (wr & a_rld_hi) begin
                rld_q[15:8] <= wbyte;
            end
            if (wr & a_rld_lo) begin
                rld_q[7:0] <= wbyte;
            end
            if (evt.capture) begin
                cap_q <= cnt_q; // R17
            end
        end
    end

    // Counter
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q <= `CTT_RST_CNT;
        end else if (cnt_wr) begin
            if (a_cnt_hi) begin
                cnt_q[15:8] <= wbyte;
            end else begin
                cnt_q[7:0] <= wbyte;
            end
        end else if (inc) begin
            cnt_q <= cnt_next; // R6
        end
    end

    // Low byte held at the edge that samples the high-byte read data
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hold_q <= 8'h00;
        end else if (setup & ~pwrite & a_cnt_hi & en) begin
            hold_q <= cnt_q[7:0]; // R8 R9
        end
    end

    // Prescaler divider, idle while disabled
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_q <= 7'h00;
        end else if (!en) begin
            div_q <= 7'h00;
        end else begin
            div_q <= div_q + 7'h01;
        end
    end

    // Input synchroniser, three stages
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tin_sync_q <= 3'h0;
        end else begin
            tin_sync_q <= {tin_sync_q[1:0], tin_pin};
        end
    end

    // Capture/compare start: first edge only arms counting
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cc_state_q <= ctt_pkg::CTT_WAIT;
            en_prev_q  <= 1'b0;
        end else begin
            en_prev_q <= en;
            case (cc_state_q)
                ctt_pkg::CTT_WAIT: begin
                    if (in_edge & m_cc & ~en_rise) begin
                        cc_state_q <= ctt_pkg::CTT_RUN; // R1 R2
                    end
                end
                ctt_pkg::CTT_RUN: begin
                    if (!en | en_rise) begin
                        cc_state_q <= ctt_pkg::CTT_WAIT; // R1
                    end
                end
                default: begin
                    cc_state_q <= ctt_pkg::CTT_WAIT;
                end
            endcase
        end
    end

    // Interrupt status and mask
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stat_q <= 2'h0;
            mask_q <= 2'h0;
            irq_q  <= 1'b0;
        end else begin
            stat_q <= stat_d; // R4
            mask_q <= mask_d;
            irq_q  <= |(stat_d & mask_d);
        end
    end

    // Timer output and complementary pin driver
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tout_q    <= 1'b0;
            tout_n    <= 1'b1;
            tout_n_oe <= 1'b0;
        end else begin
            if (evt.reload) begin
                tout_q <= ~tout_q; // R11
                tout_n <= tout_q;
            end
            tout_n_oe <= m_dual; // R12
        end
    end

    // Ports from flops
    assign prdata  = prdata_q;
    assign pready  = pready_q;
    assign pslverr = pslverr_q;
    assign irq     = irq_q;
    assign tout    = tout_q;

endmodule : ctt_timer

/* ctt_props.sv */
`timescale 1ns/1ps
module ctt_props (
    input wire logic        pclk,      // Clock
    input wire logic        presetn,   // Reset, low
    input wire logic        psel,      // Select
    input wire logic        penable,   // Access
    input wire logic        pwrite,    // Write
    input wire logic [15:0] paddr,     // Address
    input wire logic [31:0] pwdata,    // Write data
    input wire logic [31:0] prdata,    // Read data
    input wire logic        pready,    // Ready
    input wire logic        pslverr,   // Error
    input wire logic        irq,       // Interrupt
    input wire logic        tin_pin,   // Pin in
    input wire logic        tout,      // Output
    input wire logic        tout_n,    // Complement
    input wire logic        tout_n_oe  // Pin drive
);
    // Write taken at this edge
    wire logic wr = psel && penable && pwrite && pready;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_rdy_first: assert property (psel && penable && !$past(penable) |-> pready)
        else $error("no ready in first access cycle");
    a_rdy_once: assert property (pready |=> !pready)
        else $error("ready held past one cycle");
    a_rdy_cause: assert property (pready |-> psel && penable)
        else $error("ready outside access");
    a_err_rdy: assert property (pslverr |-> pready)
        else $error("error without ready");
    a_err_misalign: assert property (psel && penable && paddr[1:0] != 2'h0 |-> pslverr)
        else $error("unaligned access accepted");
    a_rd_upper: assert property (pready && !pwrite |-> prdata[31:8] == 24'h000000)
        else $error("upper read bits set");
    a_tout_pair: assert property (tout_n != tout)
        else $error("outputs not complementary");
    a_irq_sticky: assert property (irq && !wr |=> irq)
        else $error("interrupt dropped without write");
    a_oe_steady: assert property (!wr && !$past(wr) |=> $stable(tout_n_oe))
        else $error("pin drive changed without write");
endmodule : ctt_props

/* ctt_pin_model.sv */
`timescale 1ns/1ps
module ctt_pin_model (
    input  wire logic pclk,      // Clock
    input  wire logic tout_n,    // Complement out
    input  wire logic tout_n_oe, // Device drives pin
    output logic      tin_pin    // Pin level
);
    logic ext_q = 1'b0; // External source level
    // Shared pin: device side wins in dual PWM mode
    assign tin_pin = tout_n_oe ? tout_n : ext_q;
    // New level just after an edge, held past the synchroniser
    task automatic drive(input logic v);
        @(posedge pclk);
        ext_q <= v;
        repeat (6) @(posedge pclk);
    endtask : drive
endmodule : ctt_pin_model

/* ctt_tb.sv */
`timescale 1ns/1ps
`include "ctt_map.svh"
module testbench;
    logic        pclk    = 1'b0;      // Clock
    logic        presetn = 1'b0;      // Reset
    logic        psel    = 1'b0;      // Select
    logic        penable = 1'b0;      // Access
    logic        pwrite  = 1'b0;      // Write
    logic [15:0] paddr   = 16'h0000;  // Address
    logic [31:0] pwdata  = 32'h0;     // Write data
    logic [31:0] prdata, rd, l1;      // Read data
    logic        pready, pslverr, err, irq, tin_pin, tout, tout_n, tout_n_oe;
    int          errors = 0, n_checks = 0, cyc = 0, c1;
    always #2.5 pclk = ~pclk;
    always @(posedge pclk) cyc <= cyc + 1;
    ctt_timer i_ctt_timer (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
        .tin_pin(tin_pin), .tout(tout), .tout_n(tout_n),
        .tout_n_oe(tout_n_oe));
    ctt_pin_model i_ctt_pin_model (.pclk(pclk), .tout_n(tout_n),
        .tout_n_oe(tout_n_oe), .tin_pin(tin_pin));
    // Compare and count
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // One APB transfer, waits for ready
    // Extra address bits exercise refusals; upper data bits exercise ignored write data
    task automatic apb(input logic w, input logic [11:0] idx,
                       input logic [7:0] wd, input logic [3:0] xa = 4'h0,
                       input logic [23:0] xd = 24'h000000);
        @(posedge pclk);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= {xa[3:2], idx, xa[1:0]};
        pwdata <= {xd, wd};
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd  = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic rdchk(input logic [11:0] idx, input logic [7:0] e);
        apb(1'b0, idx, 8'h00);
        chk(rd, {24'h000000, e});
    endtask : rdchk
    // Reset values, access kinds, mode decode, unmapped address
    task automatic t_reset;
        chk({tout, tout_n, tout_n_oe}, 32'h2);
        rdchk(`CTT_IDX_CTL0, 8'h00);
        rdchk(`CTT_IDX_CTL1, 8'h00);
        rdchk(`CTT_IDX_RLD_HI, 8'hFF);
        apb(1'b1, `CTT_IDX_CTL0, 8'hFF);
        rdchk(`CTT_IDX_CTL0, 8'hFE);
        repeat (2) @(posedge pclk);
        chk(tout_n_oe, 1);
        apb(1'b1, `CTT_IDX_CTL0, 8'h00);
        repeat (2) @(posedge pclk);
        chk(tout_n_oe, 0);
        apb(1'b0, 12'h000, 8'h00);
        chk(err, 1);
    endtask : t_reset
    // Disabled: low byte reads the live counter
    task automatic t_live;
        apb(1'b1, `CTT_IDX_CNT_HI, 8'h12);
        apb(1'b1, `CTT_IDX_CNT_LO, 8'h34);
        rdchk(`CTT_IDX_CNT_LO, 8'h34);
        rdchk(`CTT_IDX_CNT_HI, 8'h12);
    endtask : t_live
    // Capture/compare start, reload, capture, latched reads, sources
    task automatic t_capcmp;
        apb(1'b1, `CTT_IDX_IRQ_MASK, 8'h03);
        apb(1'b1, `CTT_IDX_CNT_HI, 8'h00);
        apb(1'b1, `CTT_IDX_CNT_LO, 8'h01);
        apb(1'b1, `CTT_IDX_RLD_HI, 8'h00);
        apb(1'b1, `CTT_IDX_RLD_LO, 8'h40);
        apb(1'b1, `CTT_IDX_CTL1, 8'h87);
        repeat (20) @(posedge pclk);
        rdchk(`CTT_IDX_CNT_HI, 8'h00);
        rdchk(`CTT_IDX_CNT_LO, 8'h01);
        i_ctt_pin_model.drive(1'b1);
        rdchk(`CTT_IDX_IRQ_STAT, 8'h00);
        repeat (70) @(posedge pclk);
        chk({tout, irq}, 32'h3);
        rdchk(`CTT_IDX_IRQ_STAT, 8'h02);
        apb(1'b1, `CTT_IDX_IRQ_STAT, 8'h03);
        repeat (2) @(posedge pclk);
        chk(irq, 0);
        i_ctt_pin_model.drive(1'b0);
        i_ctt_pin_model.drive(1'b1);
        rdchk(`CTT_IDX_IRQ_STAT, 8'h01);
        rdchk(`CTT_IDX_CTL0, 8'h01);
        apb(1'b0, `CTT_IDX_CAP_LO, 8'h00);
        chk(rd > 32'h1 && rd < 32'h41, 1);
        apb(1'b1, `CTT_IDX_RLD_HI, 8'hFF);
        apb(1'b0, `CTT_IDX_CNT_HI, 8'h00);
        c1 = cyc;
        apb(1'b0, `CTT_IDX_CNT_LO, 8'h00);
        l1 = rd;
        repeat (10) @(posedge pclk);
        apb(1'b0, `CTT_IDX_CNT_HI, 8'h00);
        c1 = cyc - c1;
        repeat (10) @(posedge pclk);
        apb(1'b0, `CTT_IDX_CNT_LO, 8'h00);
        chk(8'(rd[7:0] - l1[7:0]), 8'(c1));
        apb(1'b1, `CTT_IDX_CTL0, 8'h40);
        apb(1'b1, `CTT_IDX_IRQ_STAT, 8'h03);
        i_ctt_pin_model.drive(1'b0);
        i_ctt_pin_model.drive(1'b1);
        rdchk(`CTT_IDX_IRQ_STAT, 8'h00);
        apb(1'b1, `CTT_IDX_CTL0, 8'h00);
        apb(1'b1, `CTT_IDX_CTL1, 8'hC7);
        i_ctt_pin_model.drive(1'b0);
        rdchk(`CTT_IDX_IRQ_STAT, 8'h01);
    endtask : t_capcmp
    // Capture-only source, input counting, prescale, refusals
    task automatic t_modes;
        apb(1'b1, `CTT_IDX_CTL1, 8'h04);
        apb(1'b1, `CTT_IDX_IRQ_STAT, 8'h03);
        apb(1'b1, `CTT_IDX_CTL0, 8'h20);
        apb(1'b1, `CTT_IDX_RLD_HI, 8'h00);
        apb(1'b1, `CTT_IDX_RLD_LO, 8'h01);
        apb(1'b1, `CTT_IDX_CNT_HI, 8'h00);
        apb(1'b1, `CTT_IDX_CNT_LO, 8'h01);
        l1 = {31'h0, tout};
        apb(1'b1, `CTT_IDX_CTL1, 8'h84);
        c1 = cyc;
        i_ctt_pin_model.drive(1'b1);
        apb(1'b1, `CTT_IDX_CTL1, 8'h04);
        c1 = cyc - c1;
        @(posedge pclk);
        chk({tout, tout_n}, {l1[0] ^ c1[0], ~(l1[0] ^ c1[0])});
        rdchk(`CTT_IDX_IRQ_STAT, 8'h01);
        rdchk(`CTT_IDX_CTL0, 8'h21);
        rdchk(`CTT_IDX_CAP_LO, 8'h01);
        chk(irq, 1);
        apb(1'b1, `CTT_IDX_RLD_LO, 8'h10);
        apb(1'b1, `CTT_IDX_CTL1, 8'h82);
        i_ctt_pin_model.drive(1'b0);
        i_ctt_pin_model.drive(1'b1);
        i_ctt_pin_model.drive(1'b0);
        i_ctt_pin_model.drive(1'b1);
        apb(1'b1, `CTT_IDX_CTL1, 8'h02);
        rdchk(`CTT_IDX_CNT_LO, 8'h03);
        apb(1'b1, `CTT_IDX_CTL1, 8'h94);
        c1 = cyc;
        repeat (37) @(posedge pclk);
        apb(1'b1, `CTT_IDX_CTL1, 8'h14);
        c1 = cyc - c1;
        rdchk(`CTT_IDX_CNT_LO, 8'(3 + c1 / 4));
        apb(1'b0, `CTT_IDX_CTL0, 8'h00, 4'h1);
        chk(err, 1);
        apb(1'b1, `CTT_IDX_CTL0, 8'hFF, 4'h4);
        chk(err, 1);
        rdchk(`CTT_IDX_CTL0, 8'h21);
        apb(1'b1, `CTT_IDX_RLD_LO, 8'h22, 4'h0, 24'hABCDEF);
        rdchk(`CTT_IDX_RLD_LO, 8'h22);
    endtask : t_modes
    task automatic print_verdict;
        if (errors == 0 && n_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : print_verdict
    // Hang guard
    initial begin
        repeat (5000) @(posedge pclk);
        errors++;
        print_verdict();
    end
    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_live();
        t_capcmp();
        t_modes();
        print_verdict();
    end
endmodule : testbench
bind ctt_timer ctt_props i_ctt_props (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .irq(irq), .tin_pin(tin_pin), .tout(tout), .tout_n(tout_n),
    .tout_n_oe(tout_n_oe));
